/* include/rx_fifo_level_config_map.vh */
// constants for the fifo level and receive configuration register bank
// assumes a 32-bit axi4-lite slave decoding byte addresses within one word
//
// How it works
// - probe register is read-only and always returns 0x8765_4321.
// - bits 31:24 hold tx data space threshold in 64-byte blocks, reset 0x48.
// - bits 23:16 hold tx status threshold in words, reset zero.
// - bits 7:0 hold rx status threshold in words, reset zero.
// - end alignment bits 31:30: 00 four, 01 sixteen, 10 thirty-two bytes.
// - last buffer transfer is padded with words up to the chosen alignment.
// - twelve-bit dma word count raises an interrupt once that many words are read.
// - count drops by one per word read; a host write replaces it.
// - writing one to bit 15 flushes both rx fifos, then bit clears itself.
// - offset bits 12:8 reset zero, 0 to 31 bytes, shift packet start.
// - upper three offset bits may change live, applied from next word read.
// - tx space, tx status and rx status levels set status bits 9, 7, 3.
// - exhausted dma count sets status bit 20.
`ifndef RX_FIFO_LEVEL_CONFIG_MAP_VH
`define RX_FIFO_LEVEL_CONFIG_MAP_VH

// register byte offsets
`define OFF_IRQ_STATUS 8'h58
`define OFF_IRQ_MASK 8'h5c
`define OFF_BYTE_ORDER_PROBE 8'h64
`define OFF_FIFO_LEVEL_THRESHOLDS 8'h68
`define OFF_RECEIVE_CONFIG 8'h6c

// reset values
`define RST_BYTE_ORDER_PROBE 32'h8765_4321
`define RST_TX_SPACE_LEVEL 8'h48
`define RST_TX_STATUS_LEVEL 8'h00
`define RST_RX_STATUS_LEVEL 8'h00
`define RST_END_ALIGN 2'h0
`define RST_WORD_COUNT 12'h000
`define RST_OFFSET 5'h00

// field positions
`define POS_TX_SPACE_LEVEL 24
`define POS_TX_STATUS_LEVEL 16
`define POS_RX_STATUS_LEVEL 0
`define POS_END_ALIGN 30
`define POS_WORD_COUNT 16
`define POS_DISCARD 15
`define POS_OFFSET 8

// interrupt status bit positions
`define IRQ_RX_DMA 20
`define IRQ_TX_SPACE 9
`define IRQ_TX_STATUS 7
`define IRQ_RX_STATUS 3
`define IRQ_IMPLEMENTED 32'h0010_0288

// end alignment encodings
`define ALIGN_4 2'h0
`define ALIGN_16 2'h1
`define ALIGN_32 2'h2

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* rtl/rx_fifo_level_config.v */
// fifo level thresholds, receive configuration and their interrupts
// assumes fifo occupancy and word-read strobes come from logic on aclk
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rx_fifo_level_config_map.vh"

module rx_fifo_level_config (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [13:0] tx_data_free_bytes,
  input wire [8:0] tx_status_used_words,
  input wire [8:0] rx_status_used_words,
  input wire rx_data_word_read,
  input wire rx_last_word_read,
  output reg rx_end_align_4,
  output reg [1:0] rx_end_align,
  output reg [4:0] rx_start_byte_offset,
  output reg rx_pad_active,
  output reg rx_discard,
  output reg irq
);

  // configuration state
  reg [7:0] tx_space_level;
  reg [7:0] tx_status_level;
  reg [7:0] rx_status_level;
  reg [11:0] rx_transfer_word_count;
  reg [4:0] offset_cfg;
  reg [31:0] irq_status;
  reg [31:0] irq_mask;
  reg [2:0] word_pos;
  reg [2:0] pad_left;

  // write channel state
  reg aw_held;
  reg w_held;
  reg [7:0] wr_addr;
  reg [31:0] wr_data;
  reg [3:0] wr_strb;
  reg next_aw_held;
  reg next_w_held;
  reg next_bvalid;
  wire aw_take;
  wire w_take;
  wire do_write;
  wire [31:0] byte_mask;
  wire wr_fifo_level;
  wire wr_rx_cfg;
  wire wr_status;
  wire wr_mask;
  wire wr_hit;
  wire wr_count_load;
  wire [7:0] wr_word;

  // read side
  reg [31:0] read_mux;
  reg read_hit;
  wire ar_take;
  wire [7:0] rd_word;

  // event terms
  wire tx_space_cond;
  wire tx_status_cond;
  wire rx_status_cond;
  wire dma_done;
  wire [31:0] irq_set;
  wire [31:0] next_irq_status;
  wire [2:0] pos_after;
  reg [2:0] align_mask;
  wire [2:0] pad_needed;
  wire in_padding;
  wire [31:0] rx_cfg_view;
  wire [31:0] fifo_level_view;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  // write commits only once both halves are in and the last answer is gone
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign byte_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  // byte lanes dropped from the address, so decode compares full offsets
  assign wr_word = {wr_addr[7:2], 2'b00};
  assign rd_word = {s_axi_araddr[7:2], 2'b00};
  assign wr_fifo_level = do_write & (wr_word == `OFF_FIFO_LEVEL_THRESHOLDS);
  assign wr_rx_cfg = do_write & (wr_word == `OFF_RECEIVE_CONFIG);
  assign wr_status = do_write & (wr_word == `OFF_IRQ_STATUS);
  assign wr_mask = do_write & (wr_word == `OFF_IRQ_MASK);
  // probe accepts writes silently; only the write answer differs for unmapped
  assign wr_hit = (wr_word == `OFF_FIFO_LEVEL_THRESHOLDS) |
                  (wr_word == `OFF_RECEIVE_CONFIG) |
                  (wr_word == `OFF_IRQ_STATUS) |
                  (wr_word == `OFF_IRQ_MASK) |
                  (wr_word == `OFF_BYTE_ORDER_PROBE);
  // only the count lanes reload the counter; other lanes leave it running
  assign wr_count_load = wr_rx_cfg & (wr_strb[3] | wr_strb[2]);

  // next values of the write handshake
  always @* begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_bvalid = s_axi_bvalid;
    if (aw_take) begin
      next_aw_held = 1'b1;
    end
    if (w_take) begin
      next_w_held = 1'b1;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
    end else if (s_axi_bvalid & s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // write address and data capture, either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      s_axi_bvalid <= next_bvalid;
      // ready drops while a half is parked, so one write at a time
      s_axi_awready <= ~next_aw_held & ~next_bvalid;
      s_axi_wready <= ~next_w_held & ~next_bvalid;
      if (aw_take) begin
        wr_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // level comparisons, rerun every cycle
  assign tx_space_cond = tx_data_free_bytes[13:6] > tx_space_level;
  assign tx_status_cond = tx_status_used_words > {1'b0, tx_status_level};
  assign rx_status_cond = rx_status_used_words > {1'b0, rx_status_level};
  // count reaching zero by a read, not by a host write of zero
  // a reload in the same cycle wins, so the old count cannot fire late
  assign dma_done = rx_data_word_read & (rx_transfer_word_count == 12'h001) & ~wr_count_load;

  assign irq_set = ({31'h0000_0000, tx_space_cond} << `IRQ_TX_SPACE) |
                   ({31'h0000_0000, tx_status_cond} << `IRQ_TX_STATUS) |
                   ({31'h0000_0000, rx_status_cond} << `IRQ_RX_STATUS) |
                   ({31'h0000_0000, dma_done} << `IRQ_RX_DMA);
  // set wins over a write-one clear in the same cycle
  assign next_irq_status = ((irq_status & ~(wr_status ? (wr_data & byte_mask) : 32'h0000_0000))
                           | irq_set) & `IRQ_IMPLEMENTED;

  // interrupt status, mask and output
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 32'h0000_0000;
      irq_mask <= 32'h0000_0000;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      if (wr_mask) begin
        irq_mask <= ((irq_mask & ~byte_mask) | (wr_data & byte_mask)) & `IRQ_IMPLEMENTED;
      end
      // follows the status it is about to hold, not the stale one
      irq <= |(next_irq_status & (wr_mask ?
             (((irq_mask & ~byte_mask) | (wr_data & byte_mask)) & `IRQ_IMPLEMENTED) : irq_mask));
    end
  end

  // threshold register; reserved bits 15:8 are never stored
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_space_level <= `RST_TX_SPACE_LEVEL;
      tx_status_level <= `RST_TX_STATUS_LEVEL;
      rx_status_level <= `RST_RX_STATUS_LEVEL;
    end else if (wr_fifo_level) begin
      if (wr_strb[3]) begin
        tx_space_level <= wr_data[`POS_TX_SPACE_LEVEL +: 8];
      end
      if (wr_strb[2]) begin
        tx_status_level <= wr_data[`POS_TX_STATUS_LEVEL +: 8];
      end
      if (wr_strb[0]) begin
        rx_status_level <= wr_data[`POS_RX_STATUS_LEVEL +: 8];
      end
    end
  end

  // receive configuration and the self-clearing discard
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_end_align <= `RST_END_ALIGN;
      rx_transfer_word_count <= `RST_WORD_COUNT;
      offset_cfg <= `RST_OFFSET;
      rx_discard <= 1'b0;
    end else begin
      rx_discard <= wr_rx_cfg & wr_strb[1] & wr_data[`POS_DISCARD];
      if (wr_rx_cfg & wr_strb[3]) begin
        rx_end_align <= wr_data[`POS_END_ALIGN +: 2];
      end
      // a host write replaces the running count, even mid-transfer
      if (wr_count_load) begin
        rx_transfer_word_count <= {wr_strb[3] ? wr_data[27:24] : rx_transfer_word_count[11:8],
                                   wr_strb[2] ? wr_data[23:16] : rx_transfer_word_count[7:0]};
      end else if (rx_data_word_read && rx_transfer_word_count != 12'h000) begin
        rx_transfer_word_count <= rx_transfer_word_count - 12'h001;
      end
      if (wr_rx_cfg & wr_strb[1]) begin
        offset_cfg <= wr_data[`POS_OFFSET +: 5];
      end
    end
  end

  // offset seen by the receive path
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_start_byte_offset <= `RST_OFFSET;
    end else begin
      // low bits assumed static while running, so they follow directly
      rx_start_byte_offset[1:0] <= offset_cfg[1:0];
      if (rx_data_word_read || rx_discard) begin
        rx_start_byte_offset[4:2] <= offset_cfg[4:2];
      end
    end
  end

  // alignment as a word mask; reserved code falls back to four bytes
  always @* begin
    case (rx_end_align)
      `ALIGN_4: align_mask = 3'h0;
      `ALIGN_16: align_mask = 3'h3;
      `ALIGN_32: align_mask = 3'h7;
      default: align_mask = 3'h0;
    endcase
  end

  assign in_padding = pad_left != 3'h0;
  assign pos_after = word_pos + 3'h1;
  // words still missing to the next boundary after this last word
  assign pad_needed = (~pos_after + 3'h1) & align_mask;

  // word position within the buffer and padding countdown
  always @(posedge aclk) begin
    if (!aresetn) begin
      word_pos <= 3'h0;
      pad_left <= 3'h0;
      rx_pad_active <= 1'b0;
      rx_end_align_4 <= 1'b1;
    end else begin
      // one cycle behind the field, like the low bits of rx_start_byte_offset
      rx_end_align_4 <= (align_mask == 3'h0);
      if (rx_discard) begin
        word_pos <= 3'h0;
        pad_left <= 3'h0;
        rx_pad_active <= 1'b0;
      end else if (rx_data_word_read) begin
        if (in_padding) begin
          pad_left <= pad_left - 3'h1;
          rx_pad_active <= (pad_left != 3'h1);
        end else if (rx_last_word_read) begin
          // alignment sampled here; host must not move it mid-packet
          pad_left <= pad_needed;
          rx_pad_active <= (pad_needed != 3'h0);
          word_pos <= 3'h0;
        end else begin
          word_pos <= pos_after;
        end
      end
    end
  end

  // read views with reserved bits as zero
  assign fifo_level_view = {tx_space_level, tx_status_level, 8'h00, rx_status_level};
  assign rx_cfg_view = {rx_end_align, 2'h0, rx_transfer_word_count, 1'b0, 2'h0, offset_cfg,
                        8'h00};

  // read decode
  always @* begin
    read_mux = 32'h0000_0000;
    read_hit = 1'b1;
    case (rd_word)
      `OFF_BYTE_ORDER_PROBE: read_mux = `RST_BYTE_ORDER_PROBE;
      `OFF_FIFO_LEVEL_THRESHOLDS: read_mux = fifo_level_view;
      `OFF_RECEIVE_CONFIG: read_mux = rx_cfg_view;
      `OFF_IRQ_STATUS: read_mux = irq_status;
      `OFF_IRQ_MASK: read_mux = irq_mask;
      default: read_hit = 1'b0;
    endcase
  end

  // read channel: one outstanding read, answer one cycle after the take
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_mux;
      s_axi_rresp <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

`default_nettype wire

/* bench/rx_fifo_level_config_properties.sv */
// checker for the fifo level and receive configuration bank
// assumes it is bound into rx_fifo_level_config, one aclk domain
`timescale 1ns/1ps
`default_nettype none
module rx_fifo_level_config_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic rx_data_word_read,
  input wire logic rx_last_word_read,
  input wire logic rx_end_align_4,
  input wire logic [1:0] rx_end_align,
  input wire logic [4:0] rx_start_byte_offset,
  input wire logic rx_pad_active,
  input wire logic rx_discard,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // read data checked where rvalid first shows, data stands until rready
  a_probe_value: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h19
    |-> ##[1:2] s_axi_rvalid && s_axi_rdata == 32'h8765_4321) else $error("probe value wrong");
  a_level_rsvd: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h1a
    |-> ##[1:2] s_axi_rvalid && (s_axi_rdata & 32'h0000_ff00) == 32'h0) else $error("level rsvd");
  a_rxcfg_rsvd: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h1b
    |-> ##[1:2] s_axi_rvalid && (s_axi_rdata & 32'h3000_e0ff) == 32'h0) else $error("rxcfg rsvd");
  a_discard_pulse: assert property (rx_discard |=> !rx_discard)
    else $error("discard not one cycle");
  a_discard_cause: assert property (rx_discard |-> $rose(s_axi_bvalid))
    else $error("discard without write");
  // word offset may only move right after a word read or a flush
  a_offset_live: assert property (
    $changed(rx_start_byte_offset[4:2]) |-> $past(rx_data_word_read) || $past(rx_discard)
    || $past(rx_discard, 2) || rx_discard) else $error("offset moved idle");
  a_align_flag: assert property ($past(aresetn) |-> rx_end_align_4 ==
    ($past(rx_end_align) == 2'h0 || $past(rx_end_align) == 2'h3)) else $error("align flag");
  a_pad_none: assert property (
    rx_end_align_4 && !rx_pad_active && rx_data_word_read && rx_last_word_read
    |=> !rx_pad_active) else $error("pad at 4-byte");
  a_pad_start: assert property (
    $rose(rx_pad_active) |-> $past(rx_data_word_read && rx_last_word_read))
    else $error("pad without last word");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  c_discard: cover property (rx_discard);
  c_pad: cover property ($rose(rx_pad_active));
  c_irq: cover property ($rose(irq));
endmodule
bind rx_fifo_level_config rx_fifo_level_config_properties i_props (.aclk, .aresetn,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_bvalid,
  .s_axi_bready, .rx_data_word_read, .rx_last_word_read, .rx_end_align_4, .rx_end_align,
  .rx_start_byte_offset, .rx_pad_active, .rx_discard, .irq);
`default_nettype wire

/* bench/rx_word_reader.sv */
// host side reader of the rx data fifo: pops words, drains pad words
// assumes go is a one-cycle request; n words, last one flagged if with_last
`timescale 1ns/1ps
`default_nettype none
module rx_word_reader (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire logic with_last,
  input wire logic [3:0] n,
  input wire logic rx_pad_active,
  output logic rx_data_word_read,
  output logic rx_last_word_read,
  output logic busy,
  output logic [3:0] pads
);
  logic [3:0] left;
  logic gap;
  // one pop every other cycle, so the pad flag has settled before each slot
  always_ff @(posedge aclk) begin
    rx_data_word_read <= 1'b0;
    rx_last_word_read <= 1'b0;
    gap <= ~gap;
    if (!aresetn) begin
      left <= '0;
      busy <= 1'b0;
      pads <= '0;
      gap <= 1'b0;
    end else if (go) begin
      left <= n;
      busy <= 1'b1;
      pads <= '0;
    end else if (busy && gap) begin
      if (left != 0) begin
        rx_data_word_read <= 1'b1;
        rx_last_word_read <= with_last && left == 1;
        left <= left - 1;
      end else if (rx_pad_active) begin
        rx_data_word_read <= 1'b1; // host drops pad words
        pads <= pads + 1;
      end else begin
        busy <= 1'b0; // config changes only while idle
      end
    end
  end
endmodule
`default_nettype wire

/* bench/rx_fifo_level_config_bench.sv */
// self-checking bench for the fifo level and receive configuration bank
// assumes rx_word_reader plays the host popping the rx data fifo
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module rx_fifo_level_config_bench;
  logic aclk = 0, aresetn = 0, go = 0, wl = 0, busy;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0, nw = '0, pads;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, rx_data_word_read, rx_last_word_read, rx_end_align_4;
  logic rx_pad_active, rx_discard;
  logic [13:0] tx_data_free_bytes = '0;
  logic [8:0] tx_status_used_words = '0, rx_status_used_words = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rx_end_align;
  logic [4:0] rx_start_byte_offset;
  int mismatches = 0, n_checks = 0, cycles = 0, n_dump = 0;
  rx_fifo_level_config i_rx_fifo_level_config (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_data_free_bytes, .tx_status_used_words,
    .rx_status_used_words, .rx_data_word_read, .rx_last_word_read, .rx_end_align_4,
    .rx_end_align, .rx_start_byte_offset, .rx_pad_active, .rx_discard, .irq);
  rx_word_reader i_rx_word_reader (.aclk, .aresetn, .go, .with_last(wl), .n(nw),
    .rx_pad_active, .rx_data_word_read, .rx_last_word_read, .busy, .pads);
  always #12.5 aclk = ~aclk;
  // cycle ceiling well above the few hundred cycles the tests need
  always @(posedge aclk) begin
    cycles++;
    n_dump += rx_discard;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s = 4'hf, input [1:0] er = 2'h0);
    logic aw;
    logic w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    s_axi_bready <= 1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
    `CHK("bresp", er, s_axi_bresp)
  endtask
  task automatic rd(input [7:0] a, input [31:0] e, input string nm, input [1:0] er = 2'h0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
    `CHK(nm, e, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
  endtask
  task automatic pkt(input [3:0] n, input l);
    nw <= n;
    wl <= l;
    go <= 1;
    @(posedge aclk);
    go <= 0;
    @(posedge aclk);
    while (busy) @(posedge aclk);
  endtask
  task t_regs;
    rd(8'h64, 32'h8765_4321, "probe");
    rd(8'h68, 32'h4800_0000, "levels");
    rd(8'h6c, 32'h0000_0000, "rxcfg");
    wr(8'h64, 32'h0000_0000);
    rd(8'h64, 32'h8765_4321, "probe wr");
    wr(8'h80, 32'h0000_0001, 4'hf, 2'h2);
    rd(8'h80, 32'h0000_0000, "unmapped", 2'h2);
    wr(8'h68, 32'hffff_ffff);
    rd(8'h68, 32'hffff_00ff, "levels rsvd");
    wr(8'h68, 32'h1111_1111, 4'h1);
    rd(8'h68, 32'hffff_0011, "lane");
    wr(8'h6c, 32'hffff_ffff);
    rd(8'h6c, 32'hcfff_1f00, "rxcfg rsvd");
    `CHK("flushes", 1, n_dump)
    wr(8'h6c, 32'h0000_0000);
    $display("t_regs done");
  endtask
  task t_pad;
    int tbl[4][3] = '{'{1, 5, 3}, '{2, 6, 2}, '{0, 3, 0}, '{3, 2, 0}};
    foreach (tbl[i]) begin
      wr(8'h6c, tbl[i][0] << 30);
      `CHK("align", tbl[i][0][1:0], rx_end_align)
      pkt(4'(tbl[i][1]), 1);
      `CHK("pads", tbl[i][2][3:0], pads)
    end
    $display("t_pad done");
  endtask
  task t_levels;
    wr(8'h68, 32'h1005_0005);
    wr(8'h5c, 32'hffff_ffff);
    rd(8'h5c, 32'h0010_0288, "mask");
    tx_data_free_bytes <= 14'h0400;
    tx_status_used_words <= 9'h005;
    rx_status_used_words <= 9'h005;
    wr(8'h58, 32'h0000_0288);
    rd(8'h58, 32'h0000_0000, "at level");
    `CHK("irq off", 1'b0, irq)
    tx_data_free_bytes <= 14'h0440;
    tx_status_used_words <= 9'h006;
    rx_status_used_words <= 9'h006;
    wr(8'h58, 32'h0000_0288);
    rd(8'h58, 32'h0000_0288, "above");
    `CHK("irq on", 1'b1, irq)
    wr(8'h5c, 32'h0010_0000);
    `CHK("irq masked", 1'b0, irq)
    tx_data_free_bytes <= '0;
    tx_status_used_words <= '0;
    rx_status_used_words <= '0;
    wr(8'h58, 32'h0000_0288);
    rd(8'h58, 32'h0000_0000, "cleared");
    $display("t_levels done");
  endtask
  task t_offset;
    wr(8'h6c, 32'h0000_1c00);
    repeat (3) @(posedge aclk);
    `CHK("offset held", 5'h00, rx_start_byte_offset)
    pkt(1, 0);
    `CHK("offset live", 5'h1c, rx_start_byte_offset)
    wr(8'h6c, 32'h0000_1f00);
    repeat (3) @(posedge aclk);
    `CHK("offset low", 5'h1f, rx_start_byte_offset)
    $display("t_offset done");
  endtask
  task t_dma;
    wr(8'h6c, 32'h0003_0000);
    pkt(3, 0);
    rd(8'h58, 32'h0010_0000, "dma done");
    `CHK("dma irq", 1'b1, irq)
    rd(8'h6c, 32'h0000_0000, "count");
    wr(8'h58, 32'h0010_0000);
    wr(8'h6c, 32'h0005_0000);
    pkt(2, 0);
    rd(8'h6c, 32'h0003_0000, "count run");
    wr(8'h6c, 32'h0002_0000);
    pkt(1, 0);
    rd(8'h58, 32'h0000_0000, "dma early");
    pkt(1, 0);
    rd(8'h58, 32'h0010_0000, "dma reload");
    wr(8'h58, 32'h0010_0000);
    `CHK("irq clear", 1'b0, irq)
    $display("t_dma done");
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_regs();
    t_pad();
    t_levels();
    t_offset();
    t_dma();
    conclude();
  end
endmodule
`default_nettype wire
